// ===== shared/ptwr_pkg.sv
`default_nettype none
package ptwr_pkg;
  // ***********************************************
  // bus and map
  // ***********************************************
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int IW = 6;
  localparam int NTMR = 4;
  localparam logic [IW-1:0] REG_TCR1 = 6'h0A;
  localparam logic [IW-1:0] REG_TCR2 = 6'h0B;
  localparam logic [IW-1:0] REG_CNT = 6'h10;
  localparam logic [IW-1:0] REG_STAT = 6'h18;
  localparam logic [IW-1:0] REG_MASK = 6'h19;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ***********************************************
  // timer indices and fields
  // ***********************************************
  localparam int TMR_G1 = 0;
  localparam int TMR_G2 = 1;
  localparam int TMR_BAUD = 2;
  localparam int TMR_MON = 3;
  localparam int ARM_BIT = 0;
  localparam int BAUD_FLAG_BIT = 7;
  localparam int G1_RUN = 0;
  localparam int G1_PRE = 1;
  localparam int G2_RUN = 2;
  localparam int G2_PRE = 3;
  localparam int BAUD_RUN = 4;
  localparam int NIRQ = 3;
  localparam int ST_G1 = 0;
  localparam int ST_G2 = 1;
  localparam int ST_BAUD = 2;
  // ***********************************************
  // values and timing
  // ***********************************************
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [1:0] RST_PULSE_CYC = 2'h2;
  localparam logic [1:0] RST_LAST = 2'h1;
endpackage : ptwr_pkg
`default_nettype wire

// ===== shared/ptwr_tmr_if.sv
`default_nettype none
interface ptwr_tmr_if;
  logic fall;
  logic rise;
  logic run;
  logic prescale;
  logic wr_lo;
  logic wr_hi;
  logic load;
  logic [7:0] wdata;
  logic [7:0] lo;
  logic [7:0] hi;
  logic timeout;
  modport ctl (
    output fall, rise, run, prescale, wr_lo, wr_hi, load, wdata,
    input lo, hi, timeout
  );
  modport tmr (
    input fall, rise, run, prescale, wr_lo, wr_hi, load, wdata,
    output lo, hi, timeout
  );
endinterface : ptwr_tmr_if
`default_nettype wire

// ===== sim/test_ptwr_top.sv
`default_nettype none
module test_ptwr_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ptwr_pkg::*;
  // ***********************************************
  // signals and model state
  // ***********************************************
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, serial_enable, serial_active;
  logic tx_irq_in, tx_vector_irq, irq, chip_reset_n;
  logic [AW-1:0] awaddr, araddr;
  logic [DW-1:0] wdata, rdata;
  logic [3:0] wstrb, pins;
  logic [1:0] bresp, rresp;
  logic [15:0] seed;
  int errors, tests_run, cyc, rst_low, mon_to, v, t;
  int lo_c[4], hi_c[4], lo_l[4], hi_l[4];
  int tcr1, tcr2, st, mk;
  bit armed;

  ptwr_top ptwr_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .timer_clk_pins(pins), .serial_enable(serial_enable),
    .serial_active(serial_active), .tx_irq_in(tx_irq_in),
    .tx_vector_irq(tx_vector_irq), .irq(irq), .chip_reset_n(chip_reset_n)
  );

  always #2.5 aclk = ~aclk;

  // restart pulse length and hang guard
  always @(negedge aclk)
  begin
    cyc <= cyc + 1;
    if (aresetn && chip_reset_n === 1'h0)
      rst_low <= rst_low + 1;
    if (cyc == 60000)
    begin
      errors++;
      wrap_up();
    end
  end

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic int rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return int'(seed);
  endfunction : rnd

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input int i, input int d, input logic [3:0] s,
                    input logic [1:0] e);
    logic aw_go, w_go, b_go;
    logic [1:0] resp;
    awaddr <= 8'(i * 4);
    wdata <= 32'(d & 'hFF);
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(negedge aclk);
      aw_go = awvalid && awready === 1'h1;
      w_go = wvalid && wready === 1'h1;
      b_go = bvalid === 1'h1;
      resp = bresp;
      @(posedge aclk);
      if (aw_go)
        awvalid <= 1'h0;
      if (w_go)
        wvalid <= 1'h0;
    end while (!b_go);
    check(32'(resp), 32'(e), "bresp");
    bready <= 1'h0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input int i, input int e, input logic [1:0] er,
                    input string what);
    logic ar_go, r_go;
    logic [31:0] rv;
    logic [1:0] rr;
    araddr <= 8'(i * 4);
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(negedge aclk);
      ar_go = arvalid && arready === 1'h1;
      r_go = rvalid === 1'h1;
      rv = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ar_go)
        arvalid <= 1'h0;
    end while (!r_go);
    check(rv, 32'(e), what);
    check(32'(rr), 32'(er), "rresp");
    rready <= 1'h0;
    @(posedge aclk);
  endtask : rd

  // ***********************************************
  // reference model
  // ***********************************************
  task automatic put(input int i, input int d);
    int k;
    wr(i, d, 4'hF, RESP_OKAY);
    k = i - int'(REG_CNT);
    if (i == int'(REG_TCR1))
    begin
      if (d[0] && !tcr1[0])
      begin
        armed = 1;
        lo_c[3] = lo_l[3];
        hi_c[3] = hi_l[3];
      end
      if (d[7])
        st = st & 3;
      tcr1 = d & 'h7F;
    end
    else if (i == int'(REG_TCR2))
      tcr2 = d;
    else if (i == int'(REG_STAT))
      st = st & ~d;
    else if (i == int'(REG_MASK))
      mk = d & 7;
    else if (k % 2 == 0)
      lo_l[k / 2] = d;
    else
    begin
      hi_l[k / 2] = d;
      if (k / 2 < 3)
      begin
        hi_c[k / 2] = d;
        lo_c[k / 2] = lo_l[k / 2];
      end
    end
  endtask : put

  function automatic bit run_on(input int n);
    if (n == 2)
      return tcr2[4] | serial_enable;
    return n == 3 ? armed : tcr2[2 * n];
  endfunction : run_on

  function automatic bit pre_on(input int n);
    return n < 2 && tcr2[2 * n + 1];
  endfunction : pre_on

  task automatic pulse(input int n);
    pins[n] <= 1'h0;
    repeat (6) @(posedge aclk);
    if (run_on(n) && lo_c[n] == 0)
    begin
      hi_c[n] = (hi_c[n] - 1) & 'hFF;
      lo_c[n] = pre_on(n) ? lo_l[n] : 'hFF;
    end
    else if (run_on(n))
      lo_c[n]--;
    pins[n] <= 1'h1;
    repeat (6) @(posedge aclk);
    if (run_on(n) && hi_c[n] == 0 && (pre_on(n) || lo_c[n] == 0))
    begin
      lo_c[n] = lo_l[n];
      hi_c[n] = hi_l[n];
      st |= n < 2 ? 1 << n : 0;
      st |= (n == 2 && !serial_active) ? 4 : 0;
      mon_to += n == 3 ? 1 : 0;
    end
  endtask : pulse

  task automatic chk_all();
    for (int n = 0; n < 4; n++)
    begin
      rd(int'(REG_CNT) + 2 * n, lo_c[n], RESP_OKAY, "low");
      rd(int'(REG_CNT) + 2 * n + 1, hi_c[n], RESP_OKAY, "high");
    end
    rd(REG_STAT, st, RESP_OKAY, "status");
    rd(REG_MASK, mk, RESP_OKAY, "mask");
    rd(REG_TCR1, (st & 4) << 5 | tcr1, RESP_OKAY, "control one");
    rd(REG_TCR2, tcr2, RESP_OKAY, "control two");
    check(32'(irq), 32'((st & mk) != 0), "irq");
    check(32'(tx_vector_irq), 32'(tx_irq_in | (st[2] & mk[2])), "txv");
    check(32'(rst_low), 32'(2 * mon_to), "restart cycles");
  endtask : chk_all

  // ***********************************************
  // main sequence
  // ***********************************************
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {serial_enable, serial_active, tx_irq_in, awaddr, araddr} = '0;
    {wdata, wstrb, errors, tests_run, cyc, rst_low, mon_to} = '0;
    {tcr1, tcr2, st, mk, armed} = '0;
    pins = 4'hF;
    seed = 16'h8D9D;
    for (int n = 0; n < 4; n++)
    begin
      {lo_c[n], hi_c[n], lo_l[n], hi_l[n]} = {4{32'hFF}};
    end
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk_all();
    rd(63, 0, RESP_SLVERR, "unmapped");
    wr(63, 'h55, 4'hF, RESP_SLVERR);
    wr(REG_MASK, 7, 4'hE, RESP_OKAY);
    for (int k = 0; k < 16; k++)
    begin
      v = rnd();
      serial_enable <= v[0];
      serial_active <= v[1];
      tx_irq_in <= v[2];
      put(REG_TCR2, (v >> 3) & 'h1F);
      put(REG_MASK, v >> 8);
      t = (v >> 11) % 3;
      put(int'(REG_CNT) + 2 * t, rnd() & 7);
      if (v[13])
        put(int'(REG_CNT) + 2 * t + 1, rnd() & 1);
      repeat (3 + (v >> 13))
        pulse(rnd() % 4);
      if (v[14])
        put(REG_STAT, rnd() & 7);
      put(REG_TCR1, rnd() & 'hFE);
      chk_all();
    end
    put(int'(REG_CNT) + 6, 1);
    put(int'(REG_CNT) + 7, 0);
    pulse(3);
    chk_all();
    put(REG_TCR1, 1);
    chk_all();
    pulse(3);
    pulse(3);
    put(REG_TCR1, 0);
    pulse(3);
    chk_all();
    put(REG_TCR1, 1);
    chk_all();
    wrap_up();
  end
endmodule : test_ptwr_top
`default_nettype wire

// ===== src/ptwr_edge.sv
`default_nettype none
module ptwr_edge (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin and edge pulses
  input wire logic pin,
  output logic fall,
  output logic rise
);
  import ptwr_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic fall;
    logic rise;
  } ptwr_edge_st_t;
  ptwr_edge_st_t st;
  ptwr_edge_st_t next_st;
  // ***********************************************
  // two-stage sync, then edge detect
  // ***********************************************
  always_comb
  begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.fall = st.s3 && !st.s2;
    next_st.rise = !st.s3 && st.s2;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    else
      st <= next_st;
  end
  assign fall = st.fall;
  assign rise = st.rise;
endmodule : ptwr_edge
`default_nettype wire

// ===== src/ptwr_timer.sv
`default_nettype none
module ptwr_timer #(
  parameter bit HI_WR_LOADS = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control and counts
  ptwr_tmr_if.tmr bus
);
  import ptwr_pkg::*;
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] lat_lo;
    logic [7:0] lat_hi;
  } ptwr_tmr_st_t;
  ptwr_tmr_st_t st;
  ptwr_tmr_st_t next_st;
  logic zero;
  logic tick;
  assign zero = (st.hi == CNT_ZERO) && (bus.prescale || st.lo == CNT_ZERO);
  assign tick = bus.run && !bus.wr_hi && !bus.load;
  assign bus.timeout = tick && bus.rise && zero;
  assign bus.lo = st.lo;
  assign bus.hi = st.hi;
  // ***********************************************
  // count, load and reload
  // ***********************************************
  always_comb
  begin
    next_st = st;
    if (bus.wr_lo)
      next_st.lat_lo = bus.wdata;
    if (bus.wr_hi)
    begin
      next_st.lat_hi = bus.wdata;
      if (HI_WR_LOADS)
      begin
        next_st.lo = st.lat_lo;
        next_st.hi = bus.wdata;
      end
    end
    else if (bus.load)
    begin
      next_st.lo = st.lat_lo;
      next_st.hi = st.lat_hi;
    end
    else if (tick && bus.fall)
    begin
      if (st.lo == CNT_ZERO)
      begin
        next_st.hi = st.hi - CNT_ONE;
        next_st.lo = bus.prescale ? st.lat_lo : st.lo - CNT_ONE;
      end
      else
        next_st.lo = st.lo - CNT_ONE;
    end
    else if (bus.timeout)
    begin
      next_st.lo = st.lat_lo;
      next_st.hi = st.lat_hi;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '{LATCH_RST, LATCH_RST, LATCH_RST, LATCH_RST};
    else
      st <= next_st;
  end
  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_dec_lo;
    tick && bus.fall && st.lo != CNT_ZERO |=> st.lo == $past(st.lo) - CNT_ONE;
  endproperty
  a_dec_lo: assert property (p_dec_lo) else $error("low count slip");
  property p_dec_hi;
    tick && bus.fall && st.lo == CNT_ZERO |=> st.hi == $past(st.hi) - CNT_ONE;
  endproperty
  a_dec_hi: assert property (p_dec_hi) else $error("high count slip");
  property p_latch_only;
    bus.wr_lo && !bus.wr_hi && !bus.load && !(bus.run && bus.fall)
      && !bus.timeout |=> st.lo == $past(st.lo);
  endproperty
  a_latch_only: assert property (p_latch_only) else $error("lo written");
  property p_reload;
    bus.timeout |=> st.hi == $past(st.lat_hi) && st.lo == $past(st.lat_lo);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
  property p_hi_write;
    bus.wr_hi && HI_WR_LOADS |=> st.hi == $past(bus.wdata)
      && st.lo == $past(st.lat_lo);
  endproperty
  a_hi_write: assert property (p_hi_write) else $error("hi load");
endmodule : ptwr_timer
`default_nettype wire

// ===== src/ptwr_top.sv
// How it works
// - each timer clock falling edge decrements the low counter by one
// - prescaler mode on timers one and two reloads low counter at zero
// - monitor timer never uses prescaler reload
// - writing a low counter address stores into the low latch only
// - reading counter addresses returns live counts, not latches
// - falling edge with low counter at zero decrements the high counter
// - general timer reaching zero on rising edge sets its interrupt flag
// - monitor timeout drives chip reset low two cycles then releases
// - every timeout reloads both counters from their latches
// - high write on timers one, two, baud loads high latch and both counters in the same cycle
// - monitor timer stays idle until the arm bit first rises
// - each arm bit rise reloads monitor counters; a fall does nothing
// - baud edge flag clears on writing one; zero leaves it
// - baud edge flag cannot set while serial unit operates
// - baud edge interrupt shares the transmitter interrupt vector
// - serial port enabled forces baud timer into interval operation
//
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none
module ptwr_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ptwr_pkg::AW-1:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [ptwr_pkg::DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ptwr_pkg::AW-1:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [ptwr_pkg::DW-1:0] rdata,
  output logic [1:0] rresp,
  // timer clock pins
  input wire logic [ptwr_pkg::NTMR-1:0] timer_clk_pins,
  // serial unit
  input wire logic serial_enable,
  input wire logic serial_active,
  input wire logic tx_irq_in,
  output logic tx_vector_irq,
  // interrupt and restart
  output logic irq,
  output logic chip_reset_n
);
  import ptwr_pkg::*;
  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic bvalid;
    logic rvalid;
    logic wlane;
    logic armed;
    logic irq;
    logic tx_vec;
    logic chip_rst_n;
    logic [AW-1:0] awaddr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [6:0] tcr1;
    logic [7:0] tcr2;
    logic [NIRQ-1:0] status;
    logic [NIRQ-1:0] mask;
    logic [1:0] rst_cnt;
  } ptwr_top_st_t;
  ptwr_top_st_t st;
  ptwr_top_st_t next_st;
  ptwr_tmr_if tif[NTMR] ();
  logic [7:0] cnt_lo [NTMR];
  logic [7:0] cnt_hi [NTMR];
  logic [NTMR-1:0] tmo;
  logic do_wr;
  logic wen;
  logic [IW-1:0] widx;
  logic [IW-1:0] ridx;
  logic arm_rise;
  logic [NIRQ-1:0] ev_set;
  logic [NIRQ-1:0] ev_clr;
  logic [NTMR-1:0] t_run;
  logic [NTMR-1:0] t_pre;
  // ***********************************************
  // write decode
  // ***********************************************
  assign do_wr = st.aw_held && st.w_held && !st.bvalid;
  assign wen = do_wr && st.wlane;
  assign widx = st.awaddr[AW-1:2];
  assign ridx = araddr[AW-1:2];
  assign arm_rise = wen && widx == REG_TCR1 && st.wdata[ARM_BIT]
    && !st.tcr1[ARM_BIT];
  // ***********************************************
  // timer modes
  // ***********************************************
  assign t_run[TMR_G1] = st.tcr2[G1_RUN];
  assign t_run[TMR_G2] = st.tcr2[G2_RUN];
  assign t_run[TMR_BAUD] = st.tcr2[BAUD_RUN] || serial_enable;
  assign t_run[TMR_MON] = st.armed;
  assign t_pre[TMR_G1] = st.tcr2[G1_PRE];
  assign t_pre[TMR_G2] = st.tcr2[G2_PRE];
  assign t_pre[TMR_BAUD] = 1'b0;
  assign t_pre[TMR_MON] = 1'b0;
  // ***********************************************
  // timers
  // ***********************************************
  generate
    for (genvar g = 0; g < NTMR; g++)
    begin : g_tmr
      localparam logic [IW-1:0] LO_IDX = REG_CNT + IW'(2 * g);
      localparam logic [IW-1:0] HI_IDX = REG_CNT + IW'(2 * g + 1);
      ptwr_edge u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(timer_clk_pins[g]),
        .fall(tif[g].fall),
        .rise(tif[g].rise)
      );
      assign tif[g].run = t_run[g];
      assign tif[g].prescale = t_pre[g];
      assign tif[g].wr_lo = wen && widx == LO_IDX;
      assign tif[g].wr_hi = wen && widx == HI_IDX;
      assign tif[g].load = (g == TMR_MON) && arm_rise;
      assign tif[g].wdata = st.wdata;
      assign cnt_lo[g] = tif[g].lo;
      assign cnt_hi[g] = tif[g].hi;
      assign tmo[g] = tif[g].timeout;
      ptwr_timer #(
        .HI_WR_LOADS(g != TMR_MON)
      ) u_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus(tif[g].tmr)
      );
    end
  endgenerate
  // ***********************************************
  // events
  // ***********************************************
  assign ev_set[ST_G1] = tmo[TMR_G1];
  assign ev_set[ST_G2] = tmo[TMR_G2];
  assign ev_set[ST_BAUD] = tmo[TMR_BAUD] && !serial_active;
  always_comb
  begin
    ev_clr = '0;
    if (wen && widx == REG_STAT)
      ev_clr = st.wdata[NIRQ-1:0];
    if (wen && widx == REG_TCR1 && st.wdata[BAUD_FLAG_BIT])
      ev_clr[ST_BAUD] = 1'b1;
  end
  // ***********************************************
  // read mux
  // ***********************************************
  function automatic logic [8:0] rd_mux(input logic [IW-1:0] idx);
    logic [8:0] r;
    r = {1'b1, 8'h00};
    if (idx == REG_TCR1)
      r = {1'b1, st.status[ST_BAUD], st.tcr1};
    else if (idx == REG_TCR2)
      r = {1'b1, st.tcr2};
    else if (idx == REG_STAT)
      r = {1'b1, 5'h00, st.status};
    else if (idx == REG_MASK)
      r = {1'b1, 5'h00, st.mask};
    else if (idx[IW-1:3] == REG_CNT[IW-1:3])
      r = {1'b1, idx[0] ? cnt_hi[idx[2:1]] : cnt_lo[idx[2:1]]};
    else
      r = {1'b0, 8'h00};
    return r;
  endfunction : rd_mux
  function automatic logic mapped(input logic [IW-1:0] idx);
    logic m;
    m = rd_mux(idx) != 9'h000;
    return m;
  endfunction : mapped
  // ***********************************************
  // next state
  // ***********************************************
  always_comb
  begin
    logic [8:0] rv;
    rv = rd_mux(ridx);
    next_st = st;
    if (awvalid && st.aw_rdy)
    begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = awaddr;
    end
    if (wvalid && st.w_rdy)
    begin
      next_st.w_held = 1'b1;
      next_st.wdata = wdata[7:0];
      next_st.wlane = wstrb[0];
    end
    if (st.bvalid && bready)
      next_st.bvalid = 1'b0;
    if (do_wr)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      if (wen && widx == REG_TCR1)
        next_st.tcr1 = st.wdata[6:0];
      if (wen && widx == REG_TCR2)
        next_st.tcr2 = st.wdata;
      if (wen && widx == REG_MASK)
        next_st.mask = st.wdata[NIRQ-1:0];
    end
    next_st.aw_rdy = !next_st.aw_held;
    next_st.w_rdy = !next_st.w_held;
    if (st.rvalid && rready)
      next_st.rvalid = 1'b0;
    if (arvalid && st.ar_rdy)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rv[7:0];
      next_st.rresp = rv[8] ? RESP_OKAY : RESP_SLVERR;
    end
    next_st.ar_rdy = !next_st.rvalid;
    next_st.status = (st.status & ~ev_clr) | ev_set;
    if (arm_rise)
      next_st.armed = 1'b1;
    if (tmo[TMR_MON])
    begin
      next_st.rst_cnt = RST_PULSE_CYC;
      next_st.chip_rst_n = 1'b0;
    end
    else if (st.rst_cnt != 2'h0)
    begin
      next_st.rst_cnt = st.rst_cnt - RST_LAST;
      next_st.chip_rst_n = st.rst_cnt == RST_LAST;
    end
    next_st.irq = |(st.status & st.mask);
    next_st.tx_vec = tx_irq_in
      || (st.status[ST_BAUD] && st.mask[ST_BAUD]);
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.chip_rst_n <= 1'b1;
    end
    else
      st <= next_st;
  end
  // ***********************************************
  // outputs
  // ***********************************************
  assign awready = st.aw_rdy;
  assign wready = st.w_rdy;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.ar_rdy;
  assign rvalid = st.rvalid;
  assign rdata = {24'h000000, st.rdata};
  assign rresp = st.rresp;
  assign irq = st.irq;
  assign tx_vector_irq = st.tx_vec;
  assign chip_reset_n = st.chip_rst_n;
  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_restart;
    $rose(tmo[TMR_MON]) && st.rst_cnt == 2'h0
      |=> !chip_reset_n [*2] ##1 chip_reset_n;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse");
  property p_g1_flag;
    tmo[TMR_G1] ##1 st.mask[ST_G1] |=> irq;
  endproperty
  a_g1_flag: assert property (p_g1_flag) else $error("timer irq");
  property p_g2_flag;
    tmo[TMR_G2] |=> st.status[ST_G2];
  endproperty
  a_g2_flag: assert property (p_g2_flag) else $error("timer flag");
  property p_baud_block;
    serial_active && !st.status[ST_BAUD] |=> !st.status[ST_BAUD];
  endproperty
  a_baud_block: assert property (p_baud_block) else $error("flag set");
  property p_w1c;
    wen && widx == REG_TCR1 && st.wdata[BAUD_FLAG_BIT]
      && !ev_set[ST_BAUD] |=> !st.status[ST_BAUD];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_w0;
    st.status[ST_BAUD] && !(wen && widx == REG_STAT)
      && !(wen && widx == REG_TCR1 && st.wdata[BAUD_FLAG_BIT])
      |=> st.status[ST_BAUD];
  endproperty
  a_w0: assert property (p_w0) else $error("flag lost");
  property p_tx_vec;
    st.status[ST_BAUD] && st.mask[ST_BAUD] |=> tx_vector_irq;
  endproperty
  a_tx_vec: assert property (p_tx_vec) else $error("vector irq");
  property p_idle_mon;
    !st.armed |-> !tmo[TMR_MON];
  endproperty
  a_idle_mon: assert property (p_idle_mon) else $error("monitor ran");
  property p_forced;
    serial_enable |-> tif[TMR_BAUD].run && !tif[TMR_BAUD].prescale;
  endproperty
  a_forced: assert property (p_forced) else $error("baud mode");
  property p_read_cnt;
    arvalid && arready && ridx == REG_CNT |=> rdata[7:0] == $past(cnt_lo[0]);
  endproperty
  a_read_cnt: assert property (p_read_cnt) else $error("count read");
endmodule : ptwr_top
`default_nettype wire
